//--- core/fsp_ctrl.sv
// Operation
// - high voltage on reset only, else bus timing
// - protect all sectors before first unprotect
// - write-protect pin always driven, never floating
// - enter sequence maps first sector to region
// - exit secured region before other array access
// - identification via command writes, no high voltage
//
// Added by the designer: the address map and the Wishbone register port.
`timescale 1ns/100ps
`default_nettype none
module fsp_ctrl #(
   parameter int ACC_CYC = 4,     // strobe width in clk cycles
   parameter int RST_CYC = 10     // hardware reset pulse in clk cycles
) (
   input  wire logic                        clk,        // 20 MHz clock
   input  wire logic                        rstn,       // sync reset, low
   input  wire logic                        ce,         // clock enable
   input  wire logic                        wb_cyc_i,   // wishbone cycle
   input  wire logic                        wb_stb_i,   // wishbone strobe
   input  wire logic                        wb_we_i,    // wishbone write
   input  wire logic [fsp_pkg::WB_ADR_W-1:0] wb_adr_i,  // byte address
   input  wire logic [3:0]                  wb_sel_i,   // byte enables
   input  wire logic [31:0]                 wb_dat_i,   // write data
   output logic [31:0]                      wb_dat_o,   // read data
   output logic                             wb_ack_o,   // acknowledge
   output logic [fsp_pkg::ADDR_W-1:0]       flash_addr, // address pins
   output logic [fsp_pkg::DATA_W-1:0]       flash_dq_o, // data out
   input  wire logic [fsp_pkg::DATA_W-1:0]  flash_dq_i, // data in
   output logic                             flash_dq_oe,// data drive enable
   output logic                             flash_ce_n, // chip enable
   output logic                             flash_oe_n, // output enable
   output logic                             flash_we_n, // write enable
   output logic                             flash_reset_n, // reset pin low
   output logic                             flash_reset_hv,// high_voltage_level
   output logic                             write_protect_accel_pin // wp
);
   import fsp_pkg::*;

   if (ACC_CYC < 1 || ACC_CYC > 200 || RST_CYC < 1 || RST_CYC > 200)
   begin : g_bad_param
      $error("fsp_ctrl: cycle counts must be within 1..200");
   end

   localparam logic [7:0] ACC_LAST = 8'(ACC_CYC - 1);
   localparam logic [7:0] RD_LAST  = 8'(ACC_CYC + SYNC_CYC - 1);
   localparam logic [7:0] RST_LAST = 8'(RST_CYC - 1);
   localparam logic [NGRP-1:0] ALL_PROT = '1;

   fsp_state_type         state_q;
   fsp_op_type            op_q;
   logic [7:0]            cnt_q;
   logic [ADDR_W-1:0]     addr_q;
   logic [DATA_W-1:0]     wdata_q;
   logic [DATA_W-1:0]     rdata_q;
   logic [DATA_W-1:0]     dq_s1_q;
   logic [DATA_W-1:0]     dq_s2_q;
   logic [NGRP-1:0]       shadow_q;
   logic                  cap_q;
   logic                  wp_q;
   logic                  top_q;
   logic                  sec_q;
   logic                  lock_q;
   logic                  refused_q;
   logic                  hv_q;
   logic [GRP_W-1:0]      grp;
   logic                  outer;
   logic                  first_sect;
   logic                  wb_req;
   logic                  wr_ctrl;
   logic                  start;
   logic                  bad_cmd;
   logic                  is_wr;
   fsp_op_type            new_op;

   fsp_grp u_grp (
      .addr_hi    (addr_q[20:12]),
      .boot_top   (top_q),
      .group      (grp),
      .outermost  (outer),
      .first_sect (first_sect)
   );

   // bus decode; writes need all four byte lanes to keep fields whole
   assign wb_req  = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wr_ctrl = wb_req && wb_we_i && (wb_sel_i == 4'hf)
                    && (wb_adr_i == REG_CTRL);
   assign new_op  = fsp_op_type'(wb_dat_i[CTRL_OP_LSB +: 3]);
   assign start   = wr_ctrl && (state_q == FSP_IDLE);
   assign is_wr   = (new_op == FSP_OP_WRITE) || (new_op == FSP_OP_WR_ENTER)
                    || (new_op == FSP_OP_WR_EXIT);

   // commands refused before any pin moves
   always_comb begin
      bad_cmd = 1'b0;
      // unprotect high voltage only once every group is protected
      if (new_op == FSP_OP_HV_UNPROT && shadow_q != ALL_PROT) begin
         bad_cmd = 1'b1;
      end
      // a locked region cannot be modified, so do not try
      if (is_wr && sec_q && lock_q && first_sect) begin
         bad_cmd = 1'b1;
      end
      // in secured mapping only first-sector addresses are legal
      if ((is_wr || new_op == FSP_OP_READ) && sec_q && !first_sect) begin
         bad_cmd = 1'b1;
      end
   end

   // wishbone slave: one wait state, unmapped reads give zero
   always_ff @(posedge clk) begin
      if (!rstn) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else if (ce) begin
         wb_ack_o <= wb_req;
         wb_dat_o <= 32'h0000_0000;
         if (wb_req && !wb_we_i) begin
            case (wb_adr_i)
               REG_CTRL:   wb_dat_o <= {28'h0, cap_q, op_q};
               REG_ADDR:   wb_dat_o <= {11'h0, addr_q};
               REG_WDATA:  wb_dat_o <= {16'h0, wdata_q};
               REG_RDATA:  wb_dat_o <= {16'h0, rdata_q};
               REG_STATUS: wb_dat_o <= {19'h0, grp, 1'b0,
                                        outer, outer && !wp_q, refused_q,
                                        lock_q, hv_q, sec_q,
                                        state_q != FSP_IDLE};
               REG_CONFIG: wb_dat_o <= {30'h0, top_q, wp_q};
               REG_SHADOW: wb_dat_o <= {7'h0, shadow_q};
               default:    wb_dat_o <= 32'h0000_0000;
            endcase
         end
      end
   end

   // software-owned fields; address and data frozen while busy
   always_ff @(posedge clk) begin
      if (!rstn) begin
         addr_q   <= '0;
         wdata_q  <= '0;
         wp_q     <= RST_WP;
         top_q    <= RST_TOP;
         shadow_q <= '0;                         // ships unprotected
      end else if (ce && wb_req && wb_we_i && wb_sel_i == 4'hf) begin
         if (wb_adr_i == REG_ADDR && state_q == FSP_IDLE) begin
            addr_q <= wb_dat_i[ADDR_W-1:0];
         end
         if (wb_adr_i == REG_WDATA && state_q == FSP_IDLE) begin
            wdata_q <= wb_dat_i[DATA_W-1:0];
         end
         if (wb_adr_i == REG_CONFIG) begin
            wp_q  <= wb_dat_i[CFG_WP];
            top_q <= wb_dat_i[CFG_TOP];
         end
         if (wb_adr_i == REG_SHADOW) begin
            shadow_q <= wb_dat_i[NGRP-1:0];
         end
      end
   end

   // two-flop synchroniser on the data pins; only s2 is read
   always_ff @(posedge clk) begin
      if (!rstn) begin
         dq_s1_q <= '0;
         dq_s2_q <= '0;
      end else if (ce) begin
         dq_s1_q <= flash_dq_i;
         dq_s2_q <= dq_s1_q;
      end
   end

   // bus cycle sequencer
   always_ff @(posedge clk) begin
      if (!rstn) begin
         state_q   <= FSP_IDLE;
         op_q      <= FSP_OP_READ;
         cap_q     <= 1'b0;
         cnt_q     <= 8'h00;
         refused_q <= 1'b0;
      end else if (ce) begin
         case (state_q)
            FSP_IDLE: begin
               cnt_q <= 8'h00;
               if (start) begin
                  op_q      <= new_op;
                  cap_q     <= wb_dat_i[CTRL_CAP];
                  refused_q <= bad_cmd;
                  if (!bad_cmd && new_op == FSP_OP_HWRESET) begin
                     state_q <= FSP_RSTP;
                  end else if (!bad_cmd && new_op <= FSP_OP_WR_EXIT) begin
                     state_q <= FSP_SETUP;
                  end
               end
            end
            FSP_SETUP: state_q <= FSP_STROBE;
            FSP_STROBE: begin
               cnt_q <= 8'(cnt_q + 8'h01);
               // reads keep oe low two extra cycles for the synchroniser
               if ((op_q == FSP_OP_READ && cnt_q == RD_LAST)
                   || (op_q != FSP_OP_READ && cnt_q == ACC_LAST)) begin
                  state_q <= FSP_HOLD;
               end
            end
            FSP_HOLD: state_q <= FSP_IDLE;
            FSP_RSTP: begin
               cnt_q <= 8'(cnt_q + 8'h01);
               if (cnt_q == RST_LAST) begin
                  state_q <= FSP_IDLE;
               end
            end
            default: state_q <= FSP_IDLE;
         endcase
      end
   end

   // flash pins: plain bus write and read timing, never high voltage here
   always_ff @(posedge clk) begin
      if (!rstn) begin
         flash_addr  <= '0;
         flash_dq_o  <= '0;
         flash_dq_oe <= 1'b0;
         flash_ce_n  <= 1'b1;
         flash_oe_n  <= 1'b1;
         flash_we_n  <= 1'b1;
      end else if (ce) begin
         flash_addr <= addr_q;
         flash_dq_o <= wdata_q;
         flash_ce_n <= !(state_q == FSP_SETUP || state_q == FSP_STROBE);
         // identification and command writes use this path
         flash_we_n  <= !(state_q == FSP_SETUP && op_q != FSP_OP_READ)
                        && !(state_q == FSP_STROBE && op_q != FSP_OP_READ
                             && cnt_q != ACC_LAST);
         flash_oe_n  <= !(state_q == FSP_SETUP && op_q == FSP_OP_READ)
                        && !(state_q == FSP_STROBE && op_q == FSP_OP_READ
                             && cnt_q != RD_LAST);
         flash_dq_oe <= (state_q == FSP_SETUP || state_q == FSP_STROBE)
                        && op_q != FSP_OP_READ;
      end
   end

   // read capture; group status words come back here
   always_ff @(posedge clk) begin
      if (!rstn) begin
         rdata_q <= '0;
         lock_q  <= 1'b0;
      end else if (ce && state_q == FSP_STROBE && op_q == FSP_OP_READ
                   && cnt_q == RD_LAST) begin
         rdata_q <= dq_s2_q;
         if (cap_q) begin
            lock_q <= dq_s2_q[LOCK_BIT];
         end
      end
   end

   // secured mapping mirror: set by enter, cleared by exit or reset
   always_ff @(posedge clk) begin
      if (!rstn) begin
         sec_q <= 1'b0;
      end else if (ce) begin
         if (state_q == FSP_HOLD && op_q == FSP_OP_WR_ENTER) begin
            sec_q <= 1'b1;
         end else if (state_q == FSP_HOLD && op_q == FSP_OP_WR_EXIT) begin
            sec_q <= 1'b0;
         end else if (state_q == FSP_RSTP) begin
            sec_q <= 1'b0;
         end
      end
   end

   // reset pin: low pulse, or high voltage for temporary or permanent unprotect
   always_ff @(posedge clk) begin
      if (!rstn) begin
         flash_reset_n  <= 1'b1;
         flash_reset_hv <= 1'b0;
         hv_q           <= 1'b0;
      end else if (ce) begin
         flash_reset_n <= (state_q != FSP_RSTP);
         if (start && !bad_cmd) begin
            if (new_op == FSP_OP_HV_TEMP || new_op == FSP_OP_HV_UNPROT) begin
               hv_q <= 1'b1;
            end else if (new_op == FSP_OP_HV_OFF
                         || new_op == FSP_OP_HWRESET) begin
               hv_q <= 1'b0;
            end
         end
         flash_reset_hv <= hv_q && (state_q != FSP_RSTP);
      end
   end

   // wp always driven from a flop; low locks the outer boots
   always_ff @(posedge clk) begin
      if (!rstn) begin
         write_protect_accel_pin <= RST_WP;
      end else if (ce) begin
         write_protect_accel_pin <= wp_q;
      end
   end

   hv_only_reset_a: assert property (@(posedge clk) disable iff (!rstn)
      flash_reset_hv |-> flash_reset_n)
      else $error("high voltage while reset pin pulled low");

   we_ordinary_a: assert property (@(posedge clk) disable iff (!rstn)
      !flash_we_n |-> !flash_ce_n && flash_oe_n && flash_dq_oe)
      else $error("write strobe outside an ordinary bus cycle");

   unprot_guard_a: assert property (@(posedge clk) disable iff (!rstn)
      ce && start && new_op == FSP_OP_HV_UNPROT && shadow_q != ALL_PROT
      && !hv_q |=> !hv_q ##1 !flash_reset_hv)
      else $error("unprotect voltage before all groups protected");

   sec_enter_a: assert property (@(posedge clk) disable iff (!rstn)
      $rose(sec_q) |-> $past(op_q) == FSP_OP_WR_ENTER
      && $past(state_q) == FSP_HOLD)
      else $error("secured mapping without enter write");

   sec_reset_a: assert property (@(posedge clk) disable iff (!rstn)
      ce && state_q == FSP_RSTP |=> !sec_q)
      else $error("secured mapping survived hardware reset");

   sec_hold_a: assert property (@(posedge clk) disable iff (!rstn)
      $fell(sec_q) |-> $past(state_q) == FSP_RSTP
      || $past(op_q) == FSP_OP_WR_EXIT)
      else $error("secured mapping left without exit or reset");

   lock_refuse_a: assert property (@(posedge clk) disable iff (!rstn)
      ce && start && is_wr && sec_q && lock_q && first_sect
      |=> refused_q && state_q == FSP_IDLE ##1 flash_we_n)
      else $error("write issued to locked secured region");

   outer_wp_a: assert property (@(posedge clk) disable iff (!rstn)
      ce |=> write_protect_accel_pin == $past(wp_q))
      else $error("write-protect pin not following its setting");

   ack_pulse_a: assert property (@(posedge clk) disable iff (!rstn)
      ce && wb_ack_o |=> !wb_ack_o)
      else $error("wishbone ack held longer than one cycle");

   read_len_a: assert property (@(posedge clk) disable iff (!rstn)
      ce && state_q == FSP_SETUP && op_q == FSP_OP_READ |=> !flash_oe_n)
      else $error("read strobe missing after setup");
endmodule : fsp_ctrl
`default_nettype wire

//--- core/fsp_grp.sv
`timescale 1ns/100ps
`default_nettype none
module fsp_grp (
   input  wire logic [8:0]            addr_hi,     // address bits 20..12
   input  wire logic                  boot_top,    // 1 = top-boot map
   output logic [fsp_pkg::GRP_W-1:0]  group,       // protection_group_index
   output logic                       outermost,   // one of two outer boots
   output logic                       first_sect   // first_sector range
);
   import fsp_pkg::*;

   // one group per block, except one group per boot sector and two halves for the block at the far end
   always_comb begin
      group = 5'h00;
      if (boot_top) begin
         if (addr_hi[8:3] == 6'h3f) begin
            group = 5'(5'h11 + {2'h0, addr_hi[2:0]});
         end else if (addr_hi[8:5] == 4'hf) begin
            group = 5'h10;
         end else if (addr_hi[8:5] != 4'h0) begin
            group = 5'({1'b0, addr_hi[8:5]} + 5'h01);
         end else begin
            group = {4'h0, addr_hi[4]};
         end
      end else begin
         if (addr_hi[8:3] == 6'h00) begin
            group = 5'(5'h18 - {2'h0, addr_hi[2:0]});
         end else if (addr_hi[8:5] == 4'h0) begin
            group = 5'h10;                           // 0000xxxxx, not 000000xxx
         end else if (addr_hi[8:5] == 4'hf) begin
            group = {4'h0, ~addr_hi[4]};
         end else begin
            group = 5'(5'h10 - {1'b0, addr_hi[8:5]});
         end
      end
   end

   // the two lowest sectors bottom-boot, two highest top-boot
   assign outermost  = boot_top ? (addr_hi[8:1] == 8'hff)
                                : (addr_hi[8:1] == 8'h00);
   assign first_sect = (addr_hi[8:3] == 6'h00);
endmodule : fsp_grp
`default_nettype wire

//--- core/fsp_pkg.sv
package fsp_pkg;
   // widths of the flash bus and of the register bus
   localparam int ADDR_W    = 21;
   localparam int DATA_W    = 16;
   localparam int GRP_W     = 5;
   localparam int NGRP      = 25;
   localparam int WB_ADR_W  = 8;
   localparam int SYNC_CYC  = 2;

   // register byte offsets
   localparam logic [7:0] REG_CTRL   = 8'h00;
   localparam logic [7:0] REG_ADDR   = 8'h04;
   localparam logic [7:0] REG_WDATA  = 8'h08;
   localparam logic [7:0] REG_RDATA  = 8'h0c;
   localparam logic [7:0] REG_STATUS = 8'h10;
   localparam logic [7:0] REG_CONFIG = 8'h14;
   localparam logic [7:0] REG_SHADOW = 8'h18;

   // control field positions
   localparam int CTRL_OP_LSB = 0;
   localparam int CTRL_CAP    = 3;

   // status field positions
   localparam int ST_BUSY    = 0;
   localparam int ST_SECURED = 1;
   localparam int ST_HV      = 2;
   localparam int ST_LOCKIND = 3;
   localparam int ST_REFUSED = 4;
   localparam int ST_WPBLOCK = 5;
   localparam int ST_OUTER   = 6;
   localparam int ST_GRP_LSB = 8;

   // config field positions and reset values
   localparam int CFG_WP  = 0;
   localparam int CFG_TOP = 1;
   localparam logic RST_WP  = 1'b1;
   localparam logic RST_TOP = 1'b0;

   // bit of the identification word that shows the region lock
   localparam int LOCK_BIT = 7;

   typedef enum logic [2:0] {
      FSP_OP_READ      = 3'h0,
      FSP_OP_WRITE     = 3'h1,
      FSP_OP_WR_ENTER  = 3'h2,
      FSP_OP_WR_EXIT   = 3'h3,
      FSP_OP_HWRESET   = 3'h4,
      FSP_OP_HV_TEMP   = 3'h5,
      FSP_OP_HV_UNPROT = 3'h6,
      FSP_OP_HV_OFF    = 3'h7
   } fsp_op_type;

   // gray order along idle, setup, strobe, hold; reset pulse off the path
   typedef enum logic [2:0] {
      FSP_IDLE   = 3'h0,
      FSP_SETUP  = 3'h1,
      FSP_STROBE = 3'h3,
      FSP_HOLD   = 3'h2,
      FSP_RSTP   = 3'h6
   } fsp_state_type;
endpackage : fsp_pkg

//--- tb/fsp_flash_model.sv
`timescale 1ns/100ps
`default_nettype none
module fsp_flash_model #(
   parameter logic LOCK_IND = 1'b1  // arbitrary part variant
) (
   input  wire logic [15:0] dq_o,   // data from the controller
   input  wire logic        dq_oe,  // controller drives dq
   input  wire logic        ce_n,   // chip enable
   input  wire logic        oe_n,   // output enable
   input  wire logic        we_n,   // write enable
   output logic      [15:0] dq_i    // data to the controller
);
   logic [15:0] word_q = 16'h0;     // one stored word, no sector map
   logic [15:0] hold_q = 16'h0;     // last value put on the bus
   logic [15:0] val;
   logic        drv;
   // parts ship unprotected, so every write is taken
   always @(posedge we_n) if (!ce_n && dq_oe) word_q <= dq_o;
   // indicator sits fixed on data line seven
   assign val = {word_q[15:8], LOCK_IND, word_q[6:0]};
   assign drv = !ce_n && !oe_n && !dq_oe;
   // a released bus shows the inverse, so a late sample cannot match
   always @(negedge drv) hold_q = val;
   assign dq_i = drv ? val : ~hold_q;
endmodule : fsp_flash_model
`default_nettype wire

//--- tb/tb_fsp_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
module tb_fsp_ctrl;
   import fsp_pkg::*;
   logic              clk, rstn, ce, cyc, stb, we, ack;
   logic [7:0]        adr;
   logic [3:0]        sel;
   logic [31:0]       wdat, dato, rdat;
   logic [ADDR_W-1:0] faddr;
   logic [DATA_W-1:0] dq_o, dq_i;
   logic              dq_oe, ce_n, oe_n, we_n, rpin_n, hv, wp;
   int                error_cnt = 0;
   int                n_checks = 0;
   int                rst_lo = 0;
   logic [15:0]       gt [11] = '{
      {1'b1, 9'h1f8, 1'b0, 5'h11}, {1'b1, 9'h1ff, 1'b1, 5'h18},
      {1'b1, 9'h1fe, 1'b1, 5'h17}, {1'b1, 9'h000, 1'b0, 5'h00},
      {1'b1, 9'h1e0, 1'b0, 5'h10}, {1'b0, 9'h007, 1'b0, 5'h11},
      {1'b0, 9'h001, 1'b1, 5'h17}, {1'b0, 9'h000, 1'b1, 5'h18},
      {1'b0, 9'h018, 1'b0, 5'h10}, {1'b0, 9'h01f, 1'b0, 5'h10},
      {1'b0, 9'h1e0, 1'b0, 5'h01}};

   fsp_ctrl #(.ACC_CYC(4), .RST_CYC(10)) fsp_ctrl_i (
      .clk(clk), .rstn(rstn), .ce(ce), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
      .wb_dat_o(dato), .wb_ack_o(ack), .flash_addr(faddr),
      .flash_dq_o(dq_o), .flash_dq_i(dq_i), .flash_dq_oe(dq_oe),
      .flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n),
      .flash_reset_n(rpin_n), .flash_reset_hv(hv),
      .write_protect_accel_pin(wp));

   fsp_flash_model #(.LOCK_IND(1'b1)) fsp_flash_model_i (
      .dq_o(dq_o), .dq_oe(dq_oe), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
      .dq_i(dq_i));

   // clock and a count of cycles the reset pin is pulled low
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   always @(posedge clk) if (rstn && rpin_n === 1'b0) rst_lo++;

   task automatic chk(input string nm, input logic [31:0] seen, exp);
      n_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   // one classic cycle; read data is taken at the ack edge
   task automatic wb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
      @(posedge clk);
      cyc  <= 1'b1;
      stb  <= 1'b1;
      we   <= w;
      adr  <= a;
      wdat <= d;
      do @(posedge clk); while (ack !== 1'b1);
      rdat = dato;
      cyc  <= 1'b0;
      stb  <= 1'b0;
      we   <= 1'b0;
   endtask : wb

   // start an operation, then poll until it is no longer busy
   task automatic op(input logic [2:0] o, input logic [20:0] a,
                     input logic cap);
      wb(1'b1, REG_ADDR, {11'h0, a});
      wb(1'b1, REG_CTRL, {28'h0, cap, o});
      do wb(1'b0, REG_STATUS, 32'h0); while (rdat[ST_BUSY] !== 1'b0);
   endtask : op

   task automatic final_report;
      if (error_cnt == 0 && n_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : final_report

   // cut a hang short well beyond the expected few hundred cycles
   initial begin
      repeat (20000) @(posedge clk);
      error_cnt++;
      final_report();
   end

   initial begin
      {rstn, cyc, stb, we, adr, wdat} = '0;
      ce  = 1'b1;
      sel = 4'hf;
      repeat (20) @(posedge clk);
      rstn <= 1'b1;
      wb(1'b0, REG_CONFIG, 32'h0);
      chk("config", rdat, 32'h1);
      wb(1'b0, REG_SHADOW, 32'h0);
      chk("shadow", rdat, 32'h0);
      wb(1'b0, REG_STATUS, 32'h0);
      chk("status", 32'(rdat[4:0]), 32'h0);
      chk("wp_pin", 32'(wp), 32'h1);
      wb(1'b0, 8'h40, 32'h0);
      chk("unmapped", rdat, 32'h0);
      // group decode in both maps, write-protect pin held low
      foreach (gt[i]) begin
         wb(1'b1, REG_CONFIG, {30'h0, gt[i][15], 1'b0});
         wb(1'b1, REG_ADDR, {11'h0, gt[i][14:6], 12'h0});
         wb(1'b0, REG_STATUS, 32'h0);
         chk("group", 32'(rdat[12:8]), 32'(gt[i][4:0]));
         chk("outer", 32'(rdat[ST_OUTER]), 32'(gt[i][5]));
         chk("wpblk", 32'(rdat[ST_WPBLOCK]), 32'(gt[i][5]));
      end
      chk("wp_low", 32'(wp), 32'h0);
      wb(1'b1, REG_CONFIG, 32'h1);
      wb(1'b1, REG_ADDR, 32'h0);
      wb(1'b0, REG_STATUS, 32'h0);
      chk("wpfree", 32'(rdat[ST_WPBLOCK]), 32'h0);
      // ordinary program then read back over the bus
      wb(1'b1, REG_WDATA, 32'ha5c3);
      op(FSP_OP_WRITE, 21'h012345, 1'b0);
      chk("wr_ok", 32'(rdat[ST_REFUSED]), 32'h0);
      op(FSP_OP_READ, 21'h012345, 1'b0);
      chk("nolock", 32'(rdat[ST_LOCKIND]), 32'h0);
      chk("faddr", 32'(faddr), 32'h012345);
      wb(1'b0, REG_RDATA, 32'h0);
      chk("rdata", rdat, 32'ha5c3);
      // secured mapping holds until the exit sequence
      op(FSP_OP_WR_ENTER, 21'h0, 1'b0);
      chk("secured", 32'(rdat[ST_SECURED]), 32'h1);
      op(FSP_OP_READ, 21'h010000, 1'b0);
      chk("outside", 32'(rdat[ST_REFUSED]), 32'h1);
      op(FSP_OP_WR_EXIT, 21'h0, 1'b0);
      chk("exited", 32'(rdat[ST_SECURED]), 32'h0);
      op(FSP_OP_READ, 21'h010000, 1'b0);
      chk("normal", 32'(rdat[ST_REFUSED]), 32'h0);
      // temporary and permanent high-voltage modes
      op(FSP_OP_HV_TEMP, 21'h0, 1'b0);
      chk("hv_on", 32'({hv, rdat[ST_HV]}), 32'h3);
      // outer boots stay blocked under temporary unprotect with wp low
      wb(1'b1, REG_CONFIG, 32'h0);
      wb(1'b0, REG_STATUS, 32'h0);
      chk("hv_wp", 32'({hv, wp, rdat[ST_WPBLOCK]}), 32'h5);
      wb(1'b1, REG_CONFIG, 32'h1);
      op(FSP_OP_HV_OFF, 21'h0, 1'b0);
      chk("hv_off", 32'({hv, rdat[ST_HV]}), 32'h0);
      op(FSP_OP_HV_UNPROT, 21'h0, 1'b0);
      chk("unp_ref", 32'({hv, rdat[ST_REFUSED]}), 32'h1);
      wb(1'b1, REG_SHADOW, 32'h1ffffff);
      wb(1'b0, REG_SHADOW, 32'h0);
      chk("shadow", rdat, 32'h1ffffff);
      op(FSP_OP_HV_UNPROT, 21'h0, 1'b0);
      chk("unp_ok", 32'({hv, rdat[ST_REFUSED]}), 32'h2);
      // locked region refuses changes; a hardware reset leaves it
      op(FSP_OP_WR_ENTER, 21'h0, 1'b0);
      op(FSP_OP_READ, 21'h0, 1'b1);
      chk("lockind", 32'(rdat[ST_LOCKIND]), 32'h1);
      op(FSP_OP_WRITE, 21'h0, 1'b0);
      chk("lockwr", 32'(rdat[ST_REFUSED]), 32'h1);
      op(FSP_OP_HWRESET, 21'h0, 1'b0);
      chk("rst_sec", 32'(rdat[ST_SECURED]), 32'h0);
      chk("rst_len", 32'(rst_lo), 32'd10);
      chk("rst_hv", 32'(hv), 32'h0);
      // a low clock enable freezes the pulse, stretching it 20 cycles
      wb(1'b1, REG_CTRL, {29'h0, FSP_OP_HWRESET});
      ce <= 1'b0;
      repeat (20) @(posedge clk);
      ce <= 1'b1;
      do wb(1'b0, REG_STATUS, 32'h0); while (rdat[ST_BUSY] !== 1'b0);
      chk("rst_frz", 32'(rst_lo), 32'd40);
      final_report();
   end
endmodule : tb_fsp_ctrl
`default_nettype wire
